// ==== core/crypto_ctl_pkg.sv ====
// Package for the crypto control and OTP programming block: offsets, fields, encodings, timing.
// Assumes a plain address/strobe register port; control registers are 16 bits in the low data bits, text C words use all 32 bits.
package crypto_ctl_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_CONTROL_LOW = 8'h00;
  localparam logic [7:0] OFF_STATUS      = 8'h04;
  localparam logic [7:0] OFF_OTP_CONTROL = 8'h08;
  localparam logic [7:0] OFF_KEY_CONFIG  = 8'h0c;
  localparam logic [7:0] OFF_TEXT_C_LO   = 8'h10;
  localparam logic [7:0] OFF_TEXT_C_HI   = 8'h14;
  localparam logic [7:0] OFF_TEXT_B_CTR  = 8'h18;

  // Control low fields
  localparam int BIT_ENABLE     = 15;
  localparam int BIT_STOP_IDLE  = 13;
  localparam int BIT_WRAP_IE    = 12;
  localparam int BIT_DONE_IE    = 11;
  localparam int BIT_FREE_IE    = 10;
  localparam int BIT_START      = 8;
  localparam int FLD_OPMODE_LSB = 4;
  localparam int BIT_CIPHER_SEL = 3;
  localparam int FLD_CHAIN_LSB  = 0;

  // Status fields
  localparam int BIT_BUSY        = 7;
  localparam int BIT_ABORTED     = 5;
  localparam int BIT_WRAPPED     = 4;
  localparam int BIT_MODE_FAIL   = 2;
  localparam int BIT_KEY_FAIL    = 1;
  localparam int BIT_PROG_FAIL   = 0;

  // OTP control fields
  localparam int BIT_PROG_TEST   = 7;
  localparam int BIT_OTP_IE      = 6;
  localparam int BIT_TEST_MARK   = 5;
  localparam int BIT_RELOAD      = 1;
  localparam int BIT_WRITE_START = 0;
  localparam int FLD_PAGE_LSB    = 8;

  // Key config fields
  localparam int FLD_KEYSRC_LSB  = 0;
  localparam int FLD_KEYMOD_LSB  = 4;

  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [15:0] CTRL_CLEAR_KEEP = 16'ha000;

  // Operating mode encodings
  localparam logic [3:0] OP_ENCRYPT  = 4'h0;
  localparam logic [3:0] OP_DECRYPT  = 4'h1;
  localparam logic [3:0] OP_KEY_EXP  = 4'h2;
  localparam logic [3:0] OP_RANDOM   = 4'ha;
  localparam logic [3:0] OP_SKEY_ENC = 4'he;
  localparam logic [3:0] OP_SKEY_LD  = 4'hf;

  // Chaining mode encodings
  localparam logic [2:0] CH_ECB = 3'h0;
  localparam logic [2:0] CH_CBC = 3'h1;
  localparam logic [2:0] CH_CFB = 3'h2;
  localparam logic [2:0] CH_OFB = 3'h3;
  localparam logic [2:0] CH_CTR = 3'h4;

  localparam logic [3:0] PAGE_CONFIG = 4'h0;
  localparam logic [3:0] PAGE_LAST   = 4'h7;

  // Timing
  localparam int CLK_MHZ       = 25;
  localparam int OP_TIME_NS    = 2000;
  localparam int OTP_WRITE_US  = 100;
  localparam int OTP_RELOAD_US = 20;
  localparam int OP_CYCLES     = (OP_TIME_NS * CLK_MHZ) / 1000;
  localparam int FREE_CYCLE    = OP_CYCLES / 2;
  localparam int OTP_WRITE_CYCLES  = OTP_WRITE_US * CLK_MHZ;
  localparam int OTP_RELOAD_CYCLES = OTP_RELOAD_US * CLK_MHZ;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_WRITE  = 2'b01,
    ST_RELOAD = 2'b11
  } otp_state_t;

endpackage : crypto_ctl_pkg

// ==== core/crypto_ctl.sv ====
// Control register set of the crypto engine plus the OTP key store programming sequencer.
// Assumes a single-cycle register port on CLK_IN; idle and peripheral-disable arrive as pins.
// How it works
// - Key config fail flag is combinational from settings, valid while disabled.
// - Program fail set means illegal page or module disabled; write start is refused.
// - Configuration page write burns text C low 32 bits, ones only.
// - Key page write burns text C low 64 bits, ones only.
// - Write start begins programming, self clears, OTP done event if enabled.
// - Reload bit after writes copies storage back; needed to finish.
// - Reload bit self clears at finish, OTP done event if enabled.
// - Disable during reload aborts it; keys unavailable until reload completes.
// - Setting test mark also sets the program test status bit.
// - No read path exposes OTP array contents.
// - Bit 15 enables the module.
// - Bit 13 set stops the running operation when idle is entered.
// - Bit 12 gives an event when the counter wraps to zero.
// - Bit 11 gives an event when an operation completes.
// - Bit 10 gives an event when the input text is consumed.
// - Bit 8 starts the operation, self clears; software clear aborts.
// - Mode, cipher and chaining fields are locked while operating.
// - Peripheral disable clears all bits but enable and stop-idle; reset clears all bits.
// - Operating mode codes decoded; others reserved.
// - Bit 3 selects AES or DES; bits 2:0 chaining, rest reserved.
`timescale 1ns/1ns
module crypto_ctl
  import crypto_ctl_pkg::*;
#(
  parameter int OTP_WRITE_CNT  = OTP_WRITE_CYCLES,
  parameter int OTP_RELOAD_CNT = OTP_RELOAD_CYCLES
) (
  // Clock and reset
  input  wire logic        CLK_IN,
  input  wire logic        SYS_RST_IN,
  // Register port
  input  wire logic [7:0]  ADDR_IN,
  input  wire logic [31:0] WDATA_IN,
  input  wire logic        WR_IN,
  input  wire logic        RD_IN,
  output logic      [31:0] RDATA_OUT,
  // System controls
  input  wire logic        PERIPH_DISABLE_IN,
  input  wire logic        IDLE_IN,
  // Interrupt events and status
  output logic             OP_DONE_EVT_OUT,
  output logic             INPUT_FREE_EVT_OUT,
  output logic             WRAP_EVT_OUT,
  output logic             OTP_DONE_EVT_OUT,
  output logic             KEYS_VALID_OUT,
  // OTP array write port
  output logic             OTP_WE_OUT,
  output logic      [3:0]  OTP_PAGE_OUT,
  output logic      [63:0] OTP_WDATA_OUT
);

  logic [15:0] control;
  logic [15:0] next_control;
  logic [15:0] otp_ctl;
  logic [15:0] next_otp_ctl;
  logic [15:0] key_cfg;
  logic [15:0] next_key_cfg;
  logic [63:0] text_c;
  logic [63:0] next_text_c;
  logic [7:0]  ctr;
  logic [7:0]  next_ctr;
  logic        aborted;
  logic        next_aborted;
  logic        wrapped;
  logic        next_wrapped;
  logic        keys_valid;
  logic        next_keys_valid;
  logic [15:0] op_cnt;
  logic [15:0] next_op_cnt;
  logic [31:0] otp_cnt;
  logic [31:0] next_otp_cnt;
  otp_state_t  otp_st;
  otp_state_t  next_otp_st;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic        ev_done, ev_free, ev_wrap, ev_otp, we;
  logic        next_ev_done, next_ev_free, next_ev_wrap, next_ev_otp, next_we;
  logic        idle_s1, idle_s2, pdis_s1, pdis_s2;

  logic        mode_fail;
  logic        key_fail;
  logic        prog_fail;
  logic [3:0]  page;
  logic        op_busy;
  logic        otp_busy;
  logic        start_ok;
  logic [3:0]  burn_page;
  logic        burn_ok;

  assign page     = otp_ctl[FLD_PAGE_LSB +: 4];
  assign op_busy  = control[BIT_START];
  assign otp_busy = (otp_st != ST_IDLE);

  // Fail checks on one candidate setting of the low control byte
  function automatic logic mode_bad(input logic [7:0] low);
    logic bad;
    bad = 1'b0;
    case (low[FLD_OPMODE_LSB +: 4])
      OP_ENCRYPT, OP_DECRYPT, OP_KEY_EXP, OP_RANDOM, OP_SKEY_ENC, OP_SKEY_LD: bad = 1'b0;
      default: bad = 1'b1;
    endcase
    if (low[FLD_CHAIN_LSB +: 3] > CH_CTR) begin
      bad = 1'b1;
    end
    return bad;
  endfunction : mode_bad

  // DES has no counter mode; reserved key modes fail
  function automatic logic key_bad(input logic [7:0] low, input logic [15:0] kcfg);
    logic [1:0] kmode;
    kmode = kcfg[FLD_KEYMOD_LSB +: 2];
    return (kmode == 2'b10 && !low[BIT_CIPHER_SEL]) ||
           (kmode == 2'b11 && low[BIT_CIPHER_SEL]) ||
           (!low[BIT_CIPHER_SEL] && low[FLD_CHAIN_LSB +: 3] == CH_CTR);
  endfunction : key_bad

  // Fail flags follow the current settings; mode and key fail are independent of enable, program fail is set while disabled
  always_comb begin
    mode_fail = mode_bad(control[7:0]);
    key_fail  = key_bad(control[7:0], key_cfg);
    prog_fail = (page > PAGE_LAST) || !control[BIT_ENABLE];
    // A start or burn is judged on the fields written with it, so stale legal fields cannot pass it
    start_ok  = WDATA_IN[BIT_ENABLE] && !wrapped && !mode_bad(WDATA_IN[7:0]) &&
                !key_bad(WDATA_IN[7:0], key_cfg);
    burn_page = WDATA_IN[FLD_PAGE_LSB +: 4];
    burn_ok   = (burn_page <= PAGE_LAST) && control[BIT_ENABLE];
  end

  // Synchronisers for pins from other domains
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      idle_s1 <= 1'b0;
      idle_s2 <= 1'b0;
      pdis_s1 <= 1'b0;
      pdis_s2 <= 1'b0;
    end else begin
      idle_s1 <= IDLE_IN;
      idle_s2 <= idle_s1;
      pdis_s1 <= PERIPH_DISABLE_IN;
      pdis_s2 <= pdis_s1;
    end
  end

  always_comb begin
    next_control    = control;
    next_otp_ctl    = otp_ctl;
    next_key_cfg    = key_cfg;
    next_text_c     = text_c;
    next_ctr        = ctr;
    next_aborted    = aborted;
    next_wrapped    = wrapped;
    next_keys_valid = keys_valid;
    next_op_cnt     = op_cnt;
    next_otp_cnt    = otp_cnt;
    next_otp_st     = otp_st;
    next_rdata      = 32'h0000_0000;
    next_ev_done    = 1'b0;
    next_ev_free    = 1'b0;
    next_ev_wrap    = 1'b0;
    next_ev_otp     = 1'b0;
    next_we         = 1'b0;

    // Running operation: counts down, consumes input halfway, completes at zero
    if (op_busy) begin
      if (op_cnt == 16'(FREE_CYCLE)) begin
        next_ev_free = control[BIT_FREE_IE];
      end
      if (op_cnt == 16'h0001) begin
        next_control[BIT_START] = 1'b0;
        next_aborted = 1'b0;
        next_ev_done = control[BIT_DONE_IE];
        if (control[FLD_CHAIN_LSB +: 3] == CH_CTR) begin
          next_ctr = ctr + 8'h01;
          if (ctr == 8'hff) begin
            next_wrapped = 1'b1;
            next_ev_wrap = control[BIT_WRAP_IE];
          end
        end
      end
      next_op_cnt = op_cnt - 16'h0001;
      if (idle_s2 && control[BIT_STOP_IDLE]) begin
        next_control[BIT_START] = 1'b0;
        next_aborted = 1'b1;
      end
    end

    // OTP sequencer
    case (otp_st)
      ST_IDLE: begin
      end
      ST_WRITE: begin
        if (otp_cnt == 32'h0000_0001) begin
          next_otp_ctl[BIT_WRITE_START] = 1'b0;
          next_ev_otp = otp_ctl[BIT_OTP_IE];
          next_otp_st = ST_IDLE;
        end
        next_otp_cnt = otp_cnt - 32'h0000_0001;
      end
      ST_RELOAD: begin
        if (!control[BIT_ENABLE]) begin
          // Reload bit stays set so software sees that it must reload again
          next_otp_st = ST_IDLE;
          next_keys_valid = 1'b0;
        end else if (otp_cnt == 32'h0000_0001) begin
          next_otp_ctl[BIT_RELOAD] = 1'b0;
          next_ev_otp = otp_ctl[BIT_OTP_IE];
          next_keys_valid = 1'b1;
          next_otp_st = ST_IDLE;
        end
        next_otp_cnt = otp_cnt - 32'h0000_0001;
      end
      default: next_otp_st = ST_IDLE;
    endcase

    // Register writes
    if (WR_IN) begin
      case (ADDR_IN)
        OFF_CONTROL_LOW: begin
          next_control[BIT_ENABLE]    = WDATA_IN[BIT_ENABLE];
          next_control[BIT_STOP_IDLE] = WDATA_IN[BIT_STOP_IDLE];
          next_control[BIT_WRAP_IE]   = WDATA_IN[BIT_WRAP_IE];
          next_control[BIT_DONE_IE]   = WDATA_IN[BIT_DONE_IE];
          next_control[BIT_FREE_IE]   = WDATA_IN[BIT_FREE_IE];
          if (!op_busy) begin
            next_control[7:0] = WDATA_IN[7:0];
          end
          if (op_busy && !WDATA_IN[BIT_START] && next_control[BIT_START]) begin
            next_control[BIT_START] = 1'b0;
            next_aborted = 1'b1;
          end else if (!op_busy && WDATA_IN[BIT_START] && start_ok) begin
            next_control[BIT_START] = 1'b1;
            next_op_cnt = 16'(OP_CYCLES);
          end
        end
        OFF_STATUS: begin
          // Hardware set wins over a software clear in the same cycle
          if (WDATA_IN[BIT_ABORTED] == 1'b0 && !next_aborted) next_aborted = 1'b0;
          if (WDATA_IN[BIT_WRAPPED] == 1'b0 && !next_ev_wrap && !(op_busy && ctr == 8'hff && op_cnt == 16'h0001))
            next_wrapped = 1'b0;
          if (WDATA_IN[BIT_ABORTED] == 1'b0 && !(op_busy && idle_s2 && control[BIT_STOP_IDLE]))
            next_aborted = 1'b0;
        end
        OFF_OTP_CONTROL: begin
          next_otp_ctl[BIT_OTP_IE] = WDATA_IN[BIT_OTP_IE];
          if (!otp_busy) begin
            next_otp_ctl[FLD_PAGE_LSB +: 4] = WDATA_IN[FLD_PAGE_LSB +: 4];
          end
          if (WDATA_IN[BIT_TEST_MARK]) begin
            next_otp_ctl[BIT_TEST_MARK] = 1'b1;
            next_otp_ctl[BIT_PROG_TEST] = 1'b1;
          end
          if (!otp_busy && !op_busy && WDATA_IN[BIT_WRITE_START] && burn_ok) begin
            next_otp_ctl[BIT_WRITE_START] = 1'b1;
            next_otp_st = ST_WRITE;
            next_otp_cnt = 32'(OTP_WRITE_CNT);
            next_we = 1'b1;
            // A burn makes the loaded keys stale until the next reload
            next_keys_valid = 1'b0;
          end else if (!otp_busy && !op_busy && WDATA_IN[BIT_RELOAD] && control[BIT_ENABLE]) begin
            next_otp_ctl[BIT_RELOAD] = 1'b1;
            next_otp_st = ST_RELOAD;
            next_otp_cnt = 32'(OTP_RELOAD_CNT);
          end
        end
        OFF_KEY_CONFIG: begin
          if (!op_busy) begin
            next_key_cfg = {10'h000, WDATA_IN[5:0]};
          end
        end
        OFF_TEXT_C_LO: next_text_c[31:0] = WDATA_IN;
        OFF_TEXT_C_HI: next_text_c[63:32] = WDATA_IN;
        OFF_TEXT_B_CTR: begin
          if (!op_busy) begin
            next_ctr = WDATA_IN[7:0];
          end
        end
        default: begin
        end
      endcase
    end

    // Register reads; the OTP array itself has no read path
    if (RD_IN) begin
      case (ADDR_IN)
        OFF_CONTROL_LOW: next_rdata = {16'h0000, control};
        OFF_STATUS: next_rdata = {24'h00_0000, op_busy | otp_busy, 1'b0, aborted, wrapped,
                                  1'b0, mode_fail, key_fail, prog_fail};
        OFF_OTP_CONTROL: next_rdata = {16'h0000, otp_ctl};
        OFF_KEY_CONFIG: next_rdata = {16'h0000, key_cfg};
        OFF_TEXT_C_LO: next_rdata = text_c[31:0];
        OFF_TEXT_C_HI: next_rdata = text_c[63:32];
        OFF_TEXT_B_CTR: next_rdata = {24'h00_0000, ctr};
        default: next_rdata = 32'h0000_0000;
      endcase
    end

    // Peripheral disable holds the cleared state
    if (pdis_s2) begin
      next_control = control & CTRL_CLEAR_KEEP;
      next_otp_ctl = 16'h0000;
      next_key_cfg = 16'h0000;
      next_aborted = 1'b0;
      next_wrapped = 1'b0;
      next_otp_st  = ST_IDLE;
      next_ev_done = 1'b0;
      next_ev_free = 1'b0;
      next_ev_wrap = 1'b0;
      next_ev_otp  = 1'b0;
      next_we      = 1'b0;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      control    <= CONTROL_RESET;
      otp_ctl    <= 16'h0000;
      key_cfg    <= 16'h0000;
      text_c     <= 64'h0;
      ctr        <= 8'h00;
      aborted    <= 1'b0;
      wrapped    <= 1'b0;
      keys_valid <= 1'b0;
      op_cnt     <= 16'h0000;
      otp_cnt    <= 32'h0000_0000;
      otp_st     <= ST_IDLE;
      rdata      <= 32'h0000_0000;
      ev_done    <= 1'b0;
      ev_free    <= 1'b0;
      ev_wrap    <= 1'b0;
      ev_otp     <= 1'b0;
      we         <= 1'b0;
      OTP_PAGE_OUT  <= 4'h0;
      OTP_WDATA_OUT <= 64'h0;
    end else begin
      control    <= next_control;
      otp_ctl    <= next_otp_ctl;
      key_cfg    <= next_key_cfg;
      text_c     <= next_text_c;
      ctr        <= next_ctr;
      aborted    <= next_aborted;
      wrapped    <= next_wrapped;
      keys_valid <= next_keys_valid;
      op_cnt     <= next_op_cnt;
      otp_cnt    <= next_otp_cnt;
      otp_st     <= next_otp_st;
      rdata      <= next_rdata;
      ev_done    <= next_ev_done;
      ev_free    <= next_ev_free;
      ev_wrap    <= next_ev_wrap;
      ev_otp     <= next_ev_otp;
      we         <= next_we;
      if (next_we) begin
        OTP_PAGE_OUT <= burn_page;
        // Config page takes only the low word
        OTP_WDATA_OUT <= (burn_page == PAGE_CONFIG) ? {32'h0000_0000, text_c[31:0]} : text_c;
      end
    end
  end

  assign RDATA_OUT          = rdata;
  assign OP_DONE_EVT_OUT    = ev_done;
  assign INPUT_FREE_EVT_OUT = ev_free;
  assign WRAP_EVT_OUT       = ev_wrap;
  assign OTP_DONE_EVT_OUT   = ev_otp;
  assign KEYS_VALID_OUT     = keys_valid;
  assign OTP_WE_OUT         = we;

endmodule : crypto_ctl

// ==== dv/crypto_ctl_properties.sv ====
// Port checker for crypto_ctl: read port, OTP write port, events, reset.
// Assumes it is bound to crypto_ctl and sees only its ports.
`timescale 1ns/1ns
module crypto_ctl_checker
  import crypto_ctl_pkg::*;
(
  input wire logic        CLK_IN,
  input wire logic        SYS_RST_IN,
  input wire logic [7:0]  ADDR_IN,
  input wire logic [31:0] WDATA_IN,
  input wire logic        WR_IN,
  input wire logic        RD_IN,
  input wire logic [31:0] RDATA_OUT,
  input wire logic        OP_DONE_EVT_OUT,
  input wire logic        WRAP_EVT_OUT,
  input wire logic        OTP_DONE_EVT_OUT,
  input wire logic        KEYS_VALID_OUT,
  input wire logic        OTP_WE_OUT,
  input wire logic [3:0]  OTP_PAGE_OUT,
  input wire logic [63:0] OTP_WDATA_OUT
);
  logic req_q;
  always_ff @(posedge CLK_IN) begin
    req_q <= WR_IN && ADDR_IN == OFF_OTP_CONTROL && WDATA_IN[BIT_WRITE_START];
  end
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (SYS_RST_IN);
  // Array busy keeps keys invalid and blocks a second burn
  sequence burn_quiet_s;
    (!KEYS_VALID_OUT && !OTP_WE_OUT && !OTP_DONE_EVT_OUT) [*4];
  endsequence
  rdata_quiet_a: assert property (!$past(RD_IN) |-> RDATA_OUT == 32'h0)
    else $error("read data outside read slot");
  burn_cause_a: assert property (OTP_WE_OUT |-> req_q)
    else $error("array write without write start");
  burn_busy_a: assert property (OTP_WE_OUT |=> burn_quiet_s)
    else $error("activity during array write");
  page0_width_a: assert property (OTP_WE_OUT && OTP_PAGE_OUT == PAGE_CONFIG |-> OTP_WDATA_OUT[63:32] == 32'h0)
    else $error("config page upper word not zero");
  page_legal_a: assert property (OTP_WE_OUT |-> OTP_PAGE_OUT <= PAGE_LAST)
    else $error("burn of illegal page");
  done_pulse_a: assert property (OP_DONE_EVT_OUT |=> !OP_DONE_EVT_OUT)
    else $error("done event longer than a cycle");
  wrap_pulse_a: assert property (WRAP_EVT_OUT |=> !WRAP_EVT_OUT)
    else $error("wrap event longer than a cycle");
  reset_clear_a: assert property ($fell(SYS_RST_IN) |-> !OTP_WE_OUT && !KEYS_VALID_OUT && RDATA_OUT == 32'h0)
    else $error("outputs not cleared by reset");
endmodule : crypto_ctl_checker
bind crypto_ctl crypto_ctl_checker i_chk (.CLK_IN, .SYS_RST_IN, .ADDR_IN, .WDATA_IN, .WR_IN, .RD_IN, .RDATA_OUT,
  .OP_DONE_EVT_OUT, .WRAP_EVT_OUT, .OTP_DONE_EVT_OUT, .KEYS_VALID_OUT, .OTP_WE_OUT, .OTP_PAGE_OUT, .OTP_WDATA_OUT);

// ==== dv/crypto_ctl_tb.sv ====
// Self-checking bench for crypto_ctl: registers, operations, OTP burn and reload.
// Assumes short OTP counts of 8 cycles; the bench drives every input.
`timescale 1ns/1ns
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module crypto_ctl_tb;
  import crypto_ctl_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        pdis = 1'b0;
  logic        idle = 1'b0;
  logic [31:0] rdata, r;
  logic        done_e, free_e, wrap_e, otp_e, kv, we;
  logic [3:0]  page, we_page;
  logic [63:0] wd, we_data;
  int          error_cnt = 0;
  int          cmp_count = 0;
  int          n_done = 0, n_free = 0, n_wrap = 0, n_otp = 0, n_we = 0, cyc = 0;
  initial forever #20 clk = ~clk;
  crypto_ctl #(.OTP_WRITE_CNT(8), .OTP_RELOAD_CNT(8)) i_dut (.CLK_IN(clk), .SYS_RST_IN(rst), .ADDR_IN(addr),
    .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .PERIPH_DISABLE_IN(pdis), .IDLE_IN(idle),
    .OP_DONE_EVT_OUT(done_e), .INPUT_FREE_EVT_OUT(free_e), .WRAP_EVT_OUT(wrap_e), .OTP_DONE_EVT_OUT(otp_e),
    .KEYS_VALID_OUT(kv), .OTP_WE_OUT(we), .OTP_PAGE_OUT(page), .OTP_WDATA_OUT(wd));
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish
  // Counts pulses seen at each edge; tests read and clear the counts
  always @(posedge clk) begin
    cyc++;
    if (done_e === 1'b1) n_done++;
    if (free_e === 1'b1) n_free++;
    if (wrap_e === 1'b1) n_wrap++;
    if (otp_e === 1'b1) n_otp++;
    if (we === 1'b1) begin
      n_we++;
      we_page = page;
      we_data = wd;
    end
    if (cyc == 20000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 r = rdata;
  endtask : rd_reg
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic t_regs();
    logic [7:0] c [5] = '{8'h04, 8'h00, 8'h00, 8'h08, 8'h08};
    logic [7:0] k [5] = '{8'h00, 8'h00, 8'h20, 8'h30, 8'h20};
    logic       e [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
    rd_reg(OFF_CONTROL_LOW);
    `CHK("control reset", {16'h0, CONTROL_RESET}, r)
    rd_reg(OFF_STATUS);
    `CHK("prog fail off", 1'b1, r[BIT_PROG_FAIL])
    rd_reg(8'h1c);
    `CHK("unmapped", 32'h0, r)
    // Module stays disabled: the flag must still follow the settings
    for (int i = 0; i < 5; i++) begin
      wr_reg(OFF_CONTROL_LOW, {24'h0, c[i]});
      wr_reg(OFF_KEY_CONFIG, {24'h0, k[i]});
      rd_reg(OFF_STATUS);
      `CHK("key fail", e[i], r[BIT_KEY_FAIL])
    end
    wr_reg(OFF_KEY_CONFIG, 32'h0);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_ops();
    logic [3:0]  m [6] = '{OP_ENCRYPT, OP_DECRYPT, OP_KEY_EXP, OP_RANDOM, OP_SKEY_ENC, OP_SKEY_LD};
    logic [15:0] v;
    for (int i = 0; i < 6; i++) begin
      v = 16'h8c08 | {8'h0, m[i], 4'h0};
      n_done = 0;
      n_free = 0;
      wr_reg(OFF_CONTROL_LOW, {16'h0, v | 16'h0100});
      wr_reg(OFF_CONTROL_LOW, {16'h0, (v | 16'h0100) ^ 16'h00ff});
      rd_reg(OFF_CONTROL_LOW);
      `CHK("fields locked", {16'h0, v | 16'h0100}, r)
      tick(70);
      rd_reg(OFF_CONTROL_LOW);
      `CHK("start clears", {16'h0, v}, r)
      `CHK("done event", 1, n_done)
      `CHK("free event", 1, n_free)
    end
    wr_reg(OFF_CONTROL_LOW, 32'h0d08);
    rd_reg(OFF_CONTROL_LOW);
    `CHK("start needs enable", 1'b0, r[BIT_START])
    n_done = 0;
    wr_reg(OFF_CONTROL_LOW, 32'h8108);
    tick(70);
    `CHK("done masked", 0, n_done)
    wr_reg(OFF_CONTROL_LOW, 32'h8138);
    rd_reg(OFF_STATUS);
    `CHK("mode fail", 1'b1, r[BIT_MODE_FAIL])
    rd_reg(OFF_CONTROL_LOW);
    `CHK("reserved mode", 32'h8038, r)
    wr_reg(OFF_CONTROL_LOW, 32'h810d);
    rd_reg(OFF_CONTROL_LOW);
    `CHK("reserved chain", 32'h800d, r)
    wr_reg(OFF_CONTROL_LOW, 32'h8104);
    rd_reg(OFF_STATUS);
    `CHK("des ctr refused", 32'h2, r)
    $display("t_ops done");
  endtask : t_ops
  task automatic t_stop();
    n_done = 0;
    wr_reg(OFF_CONTROL_LOW, 32'h8908);
    tick(5);
    wr_reg(OFF_CONTROL_LOW, 32'h8808);
    tick(70);
    rd_reg(OFF_STATUS);
    `CHK("aborted flag", 1'b1, r[BIT_ABORTED])
    wr_reg(OFF_STATUS, 32'h0);
    wr_reg(OFF_CONTROL_LOW, 32'ha908);
    tick(5);
    @(posedge clk) idle <= 1'b1;
    tick(10);
    @(posedge clk) idle <= 1'b0;
    rd_reg(OFF_CONTROL_LOW);
    `CHK("idle stops", 1'b0, r[BIT_START])
    `CHK("no done if stopped", 0, n_done)
    wr_reg(OFF_STATUS, 32'h0);
    wr_reg(OFF_CONTROL_LOW, 32'h8908);
    tick(5);
    @(posedge clk) idle <= 1'b1;
    tick(10);
    @(posedge clk) idle <= 1'b0;
    tick(60);
    `CHK("idle runs on", 1, n_done)
    n_wrap = 0;
    wr_reg(OFF_TEXT_B_CTR, 32'hff);
    wr_reg(OFF_CONTROL_LOW, 32'h910c);
    tick(70);
    `CHK("wrap event", 1, n_wrap)
    wr_reg(OFF_CONTROL_LOW, 32'h910c);
    rd_reg(OFF_CONTROL_LOW);
    `CHK("wrap blocks start", 1'b0, r[BIT_START])
    wr_reg(OFF_STATUS, 32'h0);
    wr_reg(OFF_CONTROL_LOW, 32'hbc0b);
    pdis <= 1'b1;
    tick(5);
    @(posedge clk) pdis <= 1'b0;
    tick(3);
    rd_reg(OFF_CONTROL_LOW);
    `CHK("disable keeps", {16'h0, 16'hbc0b & CTRL_CLEAR_KEEP}, r)
    $display("t_stop done");
  endtask : t_stop
  task automatic t_otp();
    n_otp = 0;
    n_we = 0;
    wr_reg(OFF_CONTROL_LOW, 32'h8000);
    wr_reg(OFF_OTP_CONTROL, 32'h0040);
    rd_reg(OFF_STATUS);
    `CHK("page0 legal", 1'b0, r[BIT_PROG_FAIL])
    wr_reg(OFF_TEXT_C_LO, 32'ha5a50001);
    wr_reg(OFF_TEXT_C_HI, 32'h3c3c8000);
    wr_reg(OFF_OTP_CONTROL, 32'h0041);
    tick(20);
    `CHK("page0 data", {32'h0, 32'ha5a50001}, we_data)
    rd_reg(OFF_OTP_CONTROL);
    `CHK("write clears", 1'b0, r[BIT_WRITE_START])
    wr_reg(OFF_OTP_CONTROL, 32'h0340);
    wr_reg(OFF_OTP_CONTROL, 32'h0341);
    tick(20);
    `CHK("key data", 64'h3c3c8000a5a50001, we_data)
    `CHK("key page", 4'h3, we_page)
    `CHK("otp done", 2, n_otp)
    wr_reg(OFF_OTP_CONTROL, 32'h0940);
    rd_reg(OFF_STATUS);
    `CHK("page9 fail", 1'b1, r[BIT_PROG_FAIL])
    wr_reg(OFF_OTP_CONTROL, 32'h0941);
    tick(20);
    `CHK("page9 refused", 2, n_we)
    wr_reg(OFF_OTP_CONTROL, 32'h0042);
    tick(20);
    `CHK("keys valid", 1'b1, kv)
    `CHK("reload done", 3, n_otp)
    wr_reg(OFF_OTP_CONTROL, 32'h0060);
    rd_reg(OFF_OTP_CONTROL);
    `CHK("test status", 1'b1, r[BIT_PROG_TEST])
    `CHK("reload clears", 1'b0, r[BIT_RELOAD])
    wr_reg(OFF_OTP_CONTROL, 32'h0042);
    wr_reg(OFF_CONTROL_LOW, 32'h0000);
    tick(20);
    `CHK("abort invalid", 1'b0, kv)
    rd_reg(OFF_OTP_CONTROL);
    `CHK("reload held", 1'b1, r[BIT_RELOAD])
    wr_reg(OFF_CONTROL_LOW, 32'h8000);
    wr_reg(OFF_OTP_CONTROL, 32'h0002);
    tick(20);
    `CHK("recovered", 1'b1, kv)
    `CHK("otp done masked", 3, n_otp)
    $display("t_otp done");
  endtask : t_otp
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    tick(2);
    t_regs();
    t_ops();
    t_stop();
    t_otp();
    tally_and_finish();
  end
endmodule : crypto_ctl_tb
